// ===== pkg/cce_pkg.sv
// constants and types shared by the channel calibration engine
`default_nettype none
package cce_pkg;
  localparam int DW = 24;
  localparam int AW = 5;
  localparam int NCH = 4;
  localparam int ACCW = 56;
  localparam int DENW = 32;
  localparam int DLY_W = 12;
  localparam int PC_W = 8;
  localparam int PRE_LSB = 8;
  localparam int PRE_W = 4;
  localparam int CFG_W = PRE_LSB + PRE_W;
  localparam int CMD_TYPE_LSB = 0;
  localparam int CMD_CH_LSB = 4;
  localparam logic [AW-1:0] A_CONFIG = 5'h00;
  localparam logic [AW-1:0] A_CONTROL = 5'h01;
  localparam logic [AW-1:0] A_CYCLES = 5'h02;
  localparam logic [AW-1:0] A_STATUS = 5'h03;
  localparam logic [AW-1:0] A_MASK = 5'h04;
  localparam logic [AW-1:0] A_POFF = 5'h05;
  localparam logic [AW-1:0] A_CMD = 5'h06;
  localparam logic [AW-1:0] A_DCOFF = 5'h08;
  localparam logic [AW-1:0] A_ACOFF = 5'h0c;
  localparam logic [AW-1:0] A_GAIN = 5'h10;
  localparam logic [DW-1:0] CYCLES_RST = 24'h000fa0;
  localparam logic [DW-1:0] GAIN_UNITY = 24'h400000;
  localparam logic [DW-1:0] GAIN_MAX = 24'hffffff;
  localparam logic [DW-1:0] AC_REF = 24'h4ccccd;
  localparam logic [DW-1:0] DC_REF = 24'h800000;
  localparam logic [DW-1:0] SMP_MAX = 24'h7fffff;
  localparam logic [DW-1:0] SMP_MIN = 24'h800000;
  localparam int GAIN_FRAC = 22;
  localparam int CAL_SETTLE = 30;
  localparam int AC_OFF_MULT = 6;
  localparam int PHASE_STEP = 8;
  typedef enum logic [2:0] {
    CAL_NONE = 3'h0,
    CAL_DC_OFF = 3'h1,
    CAL_AC_OFF = 3'h2,
    CAL_DC_GAIN = 3'h3,
    CAL_AC_GAIN = 3'h4
  } cce_cal_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_ACCUM = 4'b0100,
    ST_DIV = 4'b1000
  } cce_state_type;
endpackage
`default_nettype wire

// ===== hw/cce_top.sv
// channel calibration engine: offset, gain, phase and power correction
//
// Implementation choices: the strobed register port and the address map.
`default_nettype none
// Overview of operation
// - dc offset calibration stores negated sample mean in the channel dc offset
// - stored dc offset is added to every instantaneous sample
// - ac offset calibration stores the mean rms level as the ac offset
// - ac offset is subtracted from every later rms result
// - gain saturates near 4; overflow marks the calibration invalid
// - ac gain calibration stores 0.6 divided by the measured rms
// - every instantaneous sample is multiplied by its channel gain
// - dc gain calibration first resets the channel gain to unity
// - dc gain calibration stores 1.0 divided by the N-sample mean
// - after dc gain calibration the calibration level reads full scale
// - 8-bit signed phase fields for channels 1 and 2, reset zero
// - one phase step delays voltage against current by eight prescaled clocks
// - power offset is added to the active power result
// - settle 30 conversions, then gather N, or 6N for ac offset
// - completion sets ready flag; event pin follows flag when masked in
module cce_top #(
  parameter int CW = 24
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic [cce_pkg::AW-1:0] I_ADDR,
  input wire logic [cce_pkg::DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [cce_pkg::DW-1:0] O_RDATA,
  input wire logic I_SMP_VALID,
  input wire logic [cce_pkg::DW-1:0] I_SMP_V1,
  input wire logic [cce_pkg::DW-1:0] I_SMP_I1,
  input wire logic [cce_pkg::DW-1:0] I_SMP_V2,
  input wire logic [cce_pkg::DW-1:0] I_SMP_I2,
  input wire logic I_RMS_VALID,
  input wire logic [cce_pkg::DW-1:0] I_RMS_V1,
  input wire logic [cce_pkg::DW-1:0] I_RMS_I1,
  input wire logic [cce_pkg::DW-1:0] I_RMS_V2,
  input wire logic [cce_pkg::DW-1:0] I_RMS_I2,
  input wire logic I_PWR_VALID,
  input wire logic [cce_pkg::DW-1:0] I_PWR,
  output logic [cce_pkg::NCH-1:0] O_INST_STB,
  output logic [cce_pkg::DW-1:0] O_INST_V1,
  output logic [cce_pkg::DW-1:0] O_INST_I1,
  output logic [cce_pkg::DW-1:0] O_INST_V2,
  output logic [cce_pkg::DW-1:0] O_INST_I2,
  output logic O_RMS_VALID,
  output logic [cce_pkg::DW-1:0] O_RMS_V1,
  output logic [cce_pkg::DW-1:0] O_RMS_I1,
  output logic [cce_pkg::DW-1:0] O_RMS_V2,
  output logic [cce_pkg::DW-1:0] O_RMS_I2,
  output logic O_PWR_VALID,
  output logic [cce_pkg::DW-1:0] O_PWR,
  output logic O_EVENT_REQ
);
  import cce_pkg::*;
  localparam int TW = CW + 3;
  logic [DW-1:0] smp [NCH];
  logic [DW-1:0] rms [NCH];
  logic [DW-1:0] inst_r [NCH];
  logic [DW-1:0] rmso_r [NCH];
  logic [DW-1:0] hold_r [NCH];
  logic [CFG_W-1:0] cfg_r;
  logic [PC_W-1:0] ctl_r;
  logic [CW-1:0] cyc_r;
  logic mask_r;
  logic [DW-1:0] poff_r;
  logic ready_r, inv_r;
  logic [DW-1:0] dcoff_r [NCH];
  logic [DW-1:0] acoff_r [NCH];
  logic [DW-1:0] gain_r [NCH];
  cce_state_type st_r;
  cce_cal_type type_r;
  logic [NCH-1:0] chm_r;
  logic [TW-1:0] cnt_r, tgt;
  logic [CW-1:0] cyc_e;
  logic [1:0] ch_r;
  logic ph2_r, dbusy_r, go_r, done_r, is_gain, store, busy;
  logic [ACCW-1:0] num_r, acc_sel, acc_abs;
  logic [DENW-1:0] den_r;
  logic signed [ACCW-1:0] acc_r [NCH];
  logic signed [ACCW-1:0] term [NCH];
  logic signed [DW:0] pre [NCH];
  logic [DENW:0] d_rem_r, sh, rem_n;
  logic [ACCW-1:0] d_quo_r;
  logic [5:0] d_cnt_r;
  logic d_run_r, div_done_r, qb, gain_ovf;
  logic [DW-1:0] mean, dc_val;
  logic wr_cfg, wr_ctl, wr_cyc, wr_stat, wr_mask, wr_poff, wr_cmd, wr_dc, wr_ac, wr_gn;
  logic cmd_ok, cmd_go, smp_d_r, tick;
  logic [PRE_W-1:0] pre_cnt_r, kf, km1;
  logic [PC_W-1:0] pc [2];
  logic [PC_W:0] mag [2];
  logic [DLY_W-1:0] dly_r [2];
  logic [1:0] pend_r, fire;
  logic [NCH-1:0] rel;
  logic signed [DW:0] pw;
  logic [DW:0] rd [NCH];

  // clip a wide signed value into the sample range
  function automatic logic [DW-1:0] sat_fn(input logic signed [49:0] x);
    if (x[49:DW-1] != {(51-DW){x[49]}})
      return x[49] ? SMP_MIN : SMP_MAX;
    return x[DW-1:0];
  endfunction

  assign smp[0] = I_SMP_V1;
  assign smp[1] = I_SMP_I1;
  assign smp[2] = I_SMP_V2;
  assign smp[3] = I_SMP_I2;
  assign rms[0] = I_RMS_V1;
  assign rms[1] = I_RMS_I1;
  assign rms[2] = I_RMS_V2;
  assign rms[3] = I_RMS_I2;
  assign O_INST_V1 = inst_r[0];
  assign O_INST_I1 = inst_r[1];
  assign O_INST_V2 = inst_r[2];
  assign O_INST_I2 = inst_r[3];
  assign O_RMS_V1 = rmso_r[0];
  assign O_RMS_I1 = rmso_r[1];
  assign O_RMS_V2 = rmso_r[2];
  assign O_RMS_I2 = rmso_r[3];

  // register port decode
  assign wr_cfg = I_WR && (I_ADDR == A_CONFIG);
  assign wr_ctl = I_WR && (I_ADDR == A_CONTROL);
  assign wr_cyc = I_WR && (I_ADDR == A_CYCLES);
  assign wr_stat = I_WR && (I_ADDR == A_STATUS);
  assign wr_mask = I_WR && (I_ADDR == A_MASK);
  assign wr_poff = I_WR && (I_ADDR == A_POFF);
  assign wr_cmd = I_WR && (I_ADDR == A_CMD);
  assign wr_dc = I_WR && (I_ADDR[AW-1:2] == A_DCOFF[AW-1:2]);
  assign wr_ac = I_WR && (I_ADDR[AW-1:2] == A_ACOFF[AW-1:2]);
  assign wr_gn = I_WR && (I_ADDR[AW-1:2] == A_GAIN[AW-1:2]);
  assign busy = (st_r != ST_IDLE);
  assign cmd_ok = (I_WDATA[2:0] != CAL_NONE) && (I_WDATA[2:0] <= CAL_AC_GAIN);
  assign cmd_go = wr_cmd && !busy && cmd_ok && (|I_WDATA[CMD_CH_LSB +: NCH]);

  // gather lengths; a zero cycle count is run as one to avoid a hang
  assign cyc_e = (cyc_r == '0) ? CW'(1) : cyc_r;
  assign tgt = (type_r == CAL_AC_OFF) ? TW'(cyc_e) * TW'(AC_OFF_MULT) : TW'(cyc_e);
  assign is_gain = (type_r == CAL_DC_GAIN) || (type_r == CAL_AC_GAIN);
  assign store = (st_r == ST_DIV) && div_done_r && (ph2_r || !is_gain);
  assign acc_sel = acc_r[ch_r];
  assign acc_abs = acc_sel[ACCW-1] ? (ACCW'(0) - acc_sel) : acc_sel;

  // per-channel correction terms and accumulator inputs
  always_comb
    for (int c = 0; c < NCH; c++)
    begin
      pre[c] = $signed({smp[c][DW-1], smp[c]}) + $signed({dcoff_r[c][DW-1], dcoff_r[c]});
      rd[c] = {1'b0, rms[c]} - {1'b0, acoff_r[c]};
      if (type_r == CAL_DC_OFF)
        term[c] = ACCW'($signed(smp[c]));
      else if (type_r == CAL_DC_GAIN)
        term[c] = ACCW'(pre[c]);
      else
        term[c] = $signed(ACCW'(rms[c]));
    end

  // serial restoring divider, one quotient bit per clock
  assign sh = {d_rem_r[DENW-1:0], d_quo_r[ACCW-1]};
  assign qb = (sh >= {1'b0, den_r});
  assign rem_n = qb ? (sh - {1'b0, den_r}) : sh;
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      d_rem_r <= '0;
      d_quo_r <= '0;
      d_cnt_r <= '0;
      d_run_r <= 1'b0;
      div_done_r <= 1'b0;
    end
    else
    begin
      div_done_r <= d_run_r && (d_cnt_r == '0);
      if (go_r)
      begin
        d_rem_r <= '0;
        d_quo_r <= num_r;
        d_cnt_r <= 6'(ACCW - 1);
        d_run_r <= 1'b1;
      end
      else if (d_run_r)
      begin
        d_rem_r <= rem_n;
        d_quo_r <= {d_quo_r[ACCW-2:0], qb};
        d_cnt_r <= d_cnt_r - 6'h01;
        d_run_r <= (d_cnt_r != '0);
      end
    end

  // calibration sequencer: settle, gather, then divide channel by channel
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      st_r <= ST_IDLE;
      type_r <= CAL_NONE;
      chm_r <= '0;
      cnt_r <= '0;
      ch_r <= '0;
      ph2_r <= 1'b0;
      dbusy_r <= 1'b0;
      go_r <= 1'b0;
      done_r <= 1'b0;
      num_r <= '0;
      den_r <= '0;
    end
    else
    begin
      go_r <= 1'b0;
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE:
          if (cmd_go)
          begin
            st_r <= ST_SETTLE;
            type_r <= cce_cal_type'(I_WDATA[CMD_TYPE_LSB +: 3]);
            chm_r <= I_WDATA[CMD_CH_LSB +: NCH];
            cnt_r <= '0;
            ch_r <= '0;
          end
        ST_SETTLE:
          if (I_SMP_VALID)
          begin
            cnt_r <= (cnt_r == TW'(CAL_SETTLE - 1)) ? '0 : cnt_r + TW'(1);
            if (cnt_r == TW'(CAL_SETTLE - 1))
              st_r <= ST_ACCUM;
          end
        ST_ACCUM:
          if (I_SMP_VALID)
          begin
            cnt_r <= cnt_r + TW'(1);
            if (cnt_r == tgt - TW'(1))
              st_r <= ST_DIV;
          end
        ST_DIV:
          if (!dbusy_r)
          begin
            if (chm_r[ch_r])
            begin
              num_r <= acc_abs;
              den_r <= DENW'(tgt);
              go_r <= 1'b1;
              dbusy_r <= 1'b1;
              ph2_r <= 1'b0;
            end
            else if (ch_r == 2'(NCH - 1))
            begin
              st_r <= ST_IDLE;
              done_r <= 1'b1;
            end
            else
              ch_r <= ch_r + 2'h1;
          end
          else if (div_done_r)
          begin
            // second pass divides the reference level by the mean just found
            if (!ph2_r && is_gain)
            begin
              num_r <= ACCW'((type_r == CAL_DC_GAIN) ? DC_REF : AC_REF)
                << GAIN_FRAC;
              den_r <= DENW'(d_quo_r[DW-1:0]);
              go_r <= 1'b1;
              ph2_r <= 1'b1;
            end
            else
            begin
              dbusy_r <= 1'b0;
              chm_r[ch_r] <= 1'b0;
            end
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end

  // accumulators run for all channels; unselected sums are simply unused
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
      for (int c = 0; c < NCH; c++)
        acc_r[c] <= '0;
    else if (cmd_go)
      for (int c = 0; c < NCH; c++)
        acc_r[c] <= '0;
    else if ((st_r == ST_ACCUM) && I_SMP_VALID)
      for (int c = 0; c < NCH; c++)
        acc_r[c] <= acc_r[c] + term[c];

  // results written back by the sequencer
  assign mean = d_quo_r[DW-1:0];
  assign dc_val = acc_sel[ACCW-1] ? (mean[DW-1] ? SMP_MAX : mean) : (DW'(0) - mean);
  assign gain_ovf = |d_quo_r[ACCW-1:DW];
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
      for (int c = 0; c < NCH; c++)
      begin
        dcoff_r[c] <= '0;
        acoff_r[c] <= '0;
        gain_r[c] <= GAIN_UNITY;
      end
    else
      for (int c = 0; c < NCH; c++)
      begin
        if (wr_dc && (I_ADDR[1:0] == 2'(c)))
          dcoff_r[c] <= I_WDATA;
        if (wr_ac && (I_ADDR[1:0] == 2'(c)))
          acoff_r[c] <= I_WDATA;
        if (wr_gn && (I_ADDR[1:0] == 2'(c)))
          gain_r[c] <= I_WDATA;
        if (cmd_go && (I_WDATA[2:0] == CAL_DC_GAIN) && I_WDATA[CMD_CH_LSB + c])
          gain_r[c] <= GAIN_UNITY;
        if (store && (ch_r == 2'(c)))
        begin
          if (type_r == CAL_DC_OFF)
            dcoff_r[c] <= dc_val;
          else if (type_r == CAL_AC_OFF)
            acoff_r[c] <= mean;
          else
            gain_r[c] <= gain_ovf ? GAIN_MAX : mean;
        end
      end

  // software registers and sticky status; a hardware set beats a clear
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      cfg_r <= '0;
      ctl_r <= '0;
      cyc_r <= CW'(CYCLES_RST);
      mask_r <= 1'b0;
      poff_r <= '0;
      ready_r <= 1'b0;
      inv_r <= 1'b0;
      O_EVENT_REQ <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= I_WDATA[CFG_W-1:0];
      if (wr_ctl)
        ctl_r <= I_WDATA[PC_W-1:0];
      if (wr_cyc)
        cyc_r <= CW'(I_WDATA);
      if (wr_mask)
        mask_r <= I_WDATA[0];
      if (wr_poff)
        poff_r <= I_WDATA;
      ready_r <= done_r || (ready_r && !(wr_stat && I_WDATA[0]));
      inv_r <= (store && is_gain && gain_ovf) || (inv_r && !(wr_stat && I_WDATA[2]));
      O_EVENT_REQ <= ready_r && mask_r;
    end

  // read data appear only in the cycle after the read strobe
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
      O_RDATA <= '0;
    else if (!I_RD)
      O_RDATA <= '0;
    else if (I_ADDR == A_CONFIG)
      O_RDATA <= DW'(cfg_r);
    else if (I_ADDR == A_CONTROL)
      O_RDATA <= DW'(ctl_r);
    else if (I_ADDR == A_CYCLES)
      O_RDATA <= DW'(cyc_r);
    else if (I_ADDR == A_STATUS)
      O_RDATA <= DW'({inv_r, busy, ready_r});
    else if (I_ADDR == A_MASK)
      O_RDATA <= DW'(mask_r);
    else if (I_ADDR == A_POFF)
      O_RDATA <= poff_r;
    else if (I_ADDR[AW-1:2] == A_DCOFF[AW-1:2])
      O_RDATA <= dcoff_r[I_ADDR[1:0]];
    else if (I_ADDR[AW-1:2] == A_ACOFF[AW-1:2])
      O_RDATA <= acoff_r[I_ADDR[1:0]];
    else if (I_ADDR[AW-1:2] == A_GAIN[AW-1:2])
      O_RDATA <= gain_r[I_ADDR[1:0]];
    else
      O_RDATA <= '0;

  // phase steps count on the prescaled clock; positive delays voltage
  assign pc[0] = cfg_r[PC_W-1:0];
  assign pc[1] = ctl_r;
  assign kf = cfg_r[PRE_LSB +: PRE_W];
  assign km1 = (kf == '0) ? '0 : kf - PRE_W'(1);
  assign tick = (pre_cnt_r >= km1);
  always_comb
    for (int p = 0; p < 2; p++)
    begin
      mag[p] = pc[p][PC_W-1] ? ((PC_W+1)'(0) - {1'b1, pc[p]}) : {1'b0, pc[p]};
      fire[p] = pend_r[p] && (dly_r[p] == '0);
      rel[2*p] = (pc[p] != '0 && !pc[p][PC_W-1]) ? fire[p] : smp_d_r;
      rel[2*p+1] = pc[p][PC_W-1] ? fire[p] : smp_d_r;
    end
  // a new sample arriving while a delay runs overwrites the held one
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      pre_cnt_r <= '0;
      pend_r <= '0;
      dly_r[0] <= '0;
      dly_r[1] <= '0;
    end
    else
    begin
      pre_cnt_r <= tick ? '0 : pre_cnt_r + PRE_W'(1);
      for (int p = 0; p < 2; p++)
        if (smp_d_r && (pc[p] != '0))
        begin
          pend_r[p] <= 1'b1;
          dly_r[p] <= DLY_W'(mag[p]) * DLY_W'(PHASE_STEP);
        end
        else if (fire[p])
          pend_r[p] <= 1'b0;
        else if (pend_r[p] && tick)
          dly_r[p] <= dly_r[p] - DLY_W'(1);
    end

  // corrected output datapath
  assign pw = $signed({I_PWR[DW-1], I_PWR}) + $signed({poff_r[DW-1], poff_r});
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        hold_r[c] <= '0;
        inst_r[c] <= '0;
        rmso_r[c] <= '0;
      end
      smp_d_r <= 1'b0;
      O_INST_STB <= '0;
      O_RMS_VALID <= 1'b0;
      O_PWR_VALID <= 1'b0;
      O_PWR <= '0;
    end
    else
    begin
      smp_d_r <= I_SMP_VALID;
      O_INST_STB <= rel;
      O_RMS_VALID <= I_RMS_VALID;
      O_PWR_VALID <= I_PWR_VALID;
      if (I_PWR_VALID)
        O_PWR <= sat_fn(50'(pw));
      for (int c = 0; c < NCH; c++)
      begin
        if (I_SMP_VALID)
          hold_r[c] <= sat_fn((50'(pre[c]) * 50'($signed({1'b0, gain_r[c]})))
            >>> GAIN_FRAC);
        if (rel[c])
          inst_r[c] <= hold_r[c];
        if (I_RMS_VALID)
          rmso_r[c] <= rd[c][DW] ? '0 : rd[c][DW-1:0];
      end
    end

  a_ready_set: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    done_r |=> ready_r ##1 (O_EVENT_REQ == $past(mask_r))) else $error("ready flag missed");
  a_busy_ignore: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (busy && wr_cmd) |=> $stable(type_r) && (st_r != ST_SETTLE || $past(st_r) == ST_SETTLE))
    else $error("command taken while busy");
  a_gain_unity: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (cmd_go && I_WDATA[2:0] == CAL_DC_GAIN && I_WDATA[CMD_CH_LSB + 2])
    |=> gain_r[2] == GAIN_UNITY)
    else $error("gain not reset to unity");
  a_settle_len: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (st_r == ST_ACCUM && $past(st_r) == ST_SETTLE) |-> $past(cnt_r) == TW'(CAL_SETTLE - 1))
    else $error("settle length wrong");
  a_accum_len: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (st_r == ST_DIV && $past(st_r) == ST_ACCUM) |-> $past(cnt_r) == $past(tgt) - TW'(1))
    else $error("gather length wrong");
  a_gain_sat: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (store && is_gain && gain_ovf && ch_r == 2'h3) |=> gain_r[3] == GAIN_MAX && inv_r)
    else $error("gain not saturated");
  a_dcoff_neg: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (store && type_r == CAL_DC_OFF && ch_r == 2'h0 && !acc_r[0][ACCW-1] && mean != '0)
    |=> dcoff_r[0][DW-1]) else $error("dc offset not negated");
  a_phase_load: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (smp_d_r && pc[0] != '0) |=> dly_r[0] == DLY_W'($past(mag[0])) * DLY_W'(PHASE_STEP))
    else $error("phase delay not loaded");
  a_rms_sub: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (I_RMS_VALID && rms[1] >= acoff_r[1]) |=> O_RMS_I1 == $past(rms[1]) - $past(acoff_r[1]))
    else $error("ac offset not subtracted");
  c_cal_done: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) done_r);
  c_gain_sat: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) store && gain_ovf);
  c_phase_fire: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) fire[0]);
endmodule
`default_nettype wire

// ===== tb/tb_cce_top.sv
// self-checking bench for the channel calibration engine
`default_nettype none
module tb_cce_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cce_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] adr = '0;
  logic [DW-1:0] wd = '0, sv = '0, su = '0, rr = '0, pw = '0;
  logic wr = 1'b0, rd = 1'b0, smv = 1'b0, rmv = 1'b0, pwv = 1'b0;
  logic [DW-1:0] rdat, iv1, ii1, iv2, ri1, po, q;
  logic [DW-1:0] ii2, rv1, rv2, ri2;
  logic [NCH-1:0] stb;
  logic rv, pv, ev;
  int n_fail = 0, checked = 0;
  int x, y, a, p, w, r, k, t;

  // 10 MHz reference clock
  always #50 clk = ~clk;

  // all four sample inputs share two buses so one pulse feeds every channel
  cce_top #(.CW(24)) i_dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(adr), .I_WDATA(wd),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_SMP_VALID(smv), .I_SMP_V1(sv), .I_SMP_I1(sv),
    .I_SMP_V2(sv), .I_SMP_I2(su), .I_RMS_VALID(rmv), .I_RMS_V1(rr), .I_RMS_I1(rr),
    .I_RMS_V2(rr), .I_RMS_I2(rr), .I_PWR_VALID(pwv), .I_PWR(pw), .O_INST_STB(stb),
    .O_INST_V1(iv1), .O_INST_I1(ii1), .O_INST_V2(iv2), .O_INST_I2(ii2), .O_RMS_VALID(rv),
    .O_RMS_V1(rv1), .O_RMS_I1(ri1), .O_RMS_V2(rv2), .O_RMS_I2(ri2), .O_PWR_VALID(pv),
    .O_PWR(po),
    .O_EVENT_REQ(ev));

  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // single comparison point
  task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask

  // divider results are compared with a small tolerance for rounding
  task automatic near(input logic [DW-1:0] s, input longint e, input int d);
    chk(s, (longint'(s) >= e - d && longint'(s) <= e + d) ? s : 24'(e));
  endtask

  // register bus: one-cycle strobes, read data only in the following cycle
  task automatic wrr(input logic [AW-1:0] ai, input int d);
    @(posedge clk);
    adr <= ai;
    wd <= d[DW-1:0];
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [AW-1:0] ai);
    @(posedge clk);
    adr <= ai;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdat;
  endtask

  // one conversion pulse
  task automatic smp(input int v, input int u);
    @(posedge clk);
    sv <= v[DW-1:0];
    su <= u[DW-1:0];
    smv <= 1'b1;
    @(posedge clk);
    smv <= 1'b0;
  endtask

  // bounded wait for one channel's release strobe; t holds the cycle count
  task automatic wst(input int i);
    for (t = 0; t < 40; t++)
    begin
      @(posedge clk);
      #1;
      if (stb[i] === 1'b1)
        break;
    end
    if (t >= 40)
    begin
      n_fail++;
      test_done();
    end
  endtask

  // rms and power results, answered one cycle later
  task automatic res(input int v, input int u);
    @(posedge clk);
    rr <= v[DW-1:0];
    pw <= u[DW-1:0];
    rmv <= 1'b1;
    pwv <= 1'b1;
    @(posedge clk);
    rmv <= 1'b0;
    pwv <= 1'b0;
    #1 chk(24'({rv, pv}), 24'h3);
  endtask

  // run a calibration, pulsing conversions until busy drops; a second
  // command is thrown in early to prove it is ignored
  task automatic cal(input int cmd, input int nmin, input int v, input int u);
    wrr(A_CMD, cmd);
    for (k = 1; k < 600; k++)
    begin
      smp(v, u);
      if (k == 2)
        wrr(A_CMD, 24'h24);
      rdr(A_STATUS);
      if (q[1] === 1'b0)
        break;
    end
    chk(24'(k >= nmin), 24'h1);
    if (k >= 600)
    begin
      n_fail++;
      test_done();
    end
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h1728));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdr(A_CONFIG);
    chk(q, 24'h0);
    rdr(A_CONTROL);
    chk(q, 24'h0);
    rdr(A_GAIN);
    chk(q, GAIN_UNITY);
    rdr(5'h07);
    chk(q, 24'h0);
    // short cycle count keeps each calibration to a few dozen conversions
    wrr(A_CYCLES, 2);
    wrr(A_MASK, 1);
    rr <= 24'h266666;
    x = $urandom_range('h1fffff) - 'h100000;
    cal(24'h11, 32, x, x);
    rdr(A_DCOFF);
    chk(q, 24'(-x));
    rdr(A_GAIN + 5'h1);
    chk(q, GAIN_UNITY);
    rdr(A_STATUS);
    chk(q & 24'h1, 24'h1);
    chk(24'(ev), 24'h1);
    wrr(A_STATUS, 1);
    rdr(A_STATUS);
    chk(q & 24'h1, 24'h0);
    chk(24'(ev), 24'h0);
    // offset and gain applied to a later sample
    wrr(A_GAIN, 24'h200000);
    y = $urandom_range('h1fffff) - 'h100000;
    smp(y, y);
    wst(0);
    chk(iv1, 24'((y - x) >>> 1));
    chk(ii1, 24'(y));
    chk(ii2, 24'(y));
    // rms offset clamps at zero, power offset is added
    a = $urandom_range('hfffff) + 'h100;
    p = $urandom_range('hfffff) - 'h80000;
    w = $urandom_range('hfffff) - 'h80000;
    wrr(A_ACOFF + 5'h1, a);
    wrr(A_POFF, p);
    res(a + 'h345, w);
    chk(ri1, 24'h345);
    chk(rv1, 24'(a + 'h345));
    chk(rv2, 24'(a + 'h345));
    chk(ri2, 24'(a + 'h345));
    chk(po, 24'(w + p));
    res(a - 1, -p);
    chk(ri1, 24'h0);
    chk(po, 24'h0);
    // phase steps of eight ticks each, both signs
    wrr(A_CONFIG, 24'h2);
    smp(y, y);
    wst(1);
    wst(0);
    chk(24'(t >= 14 && t <= 20), 24'h1);
    // prescale of two doubles the time of every phase step
    wrr(A_CONFIG, 24'h202);
    smp(y, y);
    wst(1);
    wst(0);
    chk(24'(t >= 30 && t <= 36), 24'h1);
    wrr(A_CONFIG, 24'hfe);
    smp(y, y);
    wst(0);
    wst(1);
    chk(24'(t >= 14 && t <= 20), 24'h1);
    wrr(A_CONFIG, 0);
    wrr(A_CONTROL, 24'h80);
    rdr(A_CONTROL);
    chk(q, 24'h80);
    // dc gain on two channels, one with a level too small for the range
    wrr(A_GAIN + 5'h2, 24'h100000);
    x = $urandom_range('h3fffff, 'h300000);
    cal(24'hc3, 32, x, 'h100);
    rdr(A_GAIN + 5'h2);
    near(q, (64'h1 << 45) / x, 1);
    rdr(A_GAIN + 5'h3);
    chk(q, GAIN_MAX);
    rdr(A_STATUS);
    chk(q & 24'h4, 24'h4);
    smp(x, 0);
    wst(2);
    chk(iv2, SMP_MAX);
    // ac gain against a known rms level
    wrr(A_ACOFF + 5'h1, 0);
    rr <= 24'h266666;
    cal(24'h24, 32, 0, 0);
    rdr(A_GAIN + 5'h1);
    near(q, (longint'(AC_REF) << 22) / 'h266666, 2);
    // ac offset over six times the cycle count
    wrr(A_ACOFF, 0);
    r = $urandom_range('hfffff);
    rr <= r[DW-1:0];
    cal(24'h12, 42, 0, 0);
    rdr(A_ACOFF);
    near(q, r, 1);
    test_done();
  end
endmodule
`default_nettype wire
